/* bench/testbench.sv */
/*
  testbench: processor end and one control joined by the exchange interface.
  assumes the wishbone map and timings given in the package; control on channel 3.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tpb_pkg::*;
  logic              clk, rst_i, cyc, stb, we, ack, need_svc, rx_vld, rc_q, dth_q, smc_q;
  logic [3:0]        adr, sel;
  logic [31:0]       dat_w, dat_r, d;
  logic [EXCH_W-1:0] status, ca_word, word;
  logic [DATA_W-1:0] rx_data;
  logic [3:0]        ch;
  int                failures, tests_run, rx_cnt, rc_cnt, dth_cnt, p1_cnt, p4_cnt;
  int                n_rx, n_rc, n_dth, n1, n4, smc_cnt, n_smc;
  tpb_if u_tpb_if (.clk(clk));
  tpb_host u_tpb_host (.clk_i(clk), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .bus(u_tpb_if));
  tpb_ctrl #(.CHANNEL(4'h3)) u_tpb_ctrl (.clk_i(clk), .rst_i(rst_i), .need_svc_i(need_svc),
    .status_i(status), .rx_data_o(rx_data), .rx_vld_o(rx_vld), .bus(u_tpb_if));
  tpb_bus_properties u_tpb_bus_properties (.clk(clk), .rst_i(rst_i),
    .host_exch_oe(u_tpb_if.host_exch_oe), .drive_toward_host(u_tpb_if.drive_toward_host),
    .command_phase_strobe(u_tpb_if.command_phase_strobe),
    .response_phase_strobe(u_tpb_if.response_phase_strobe),
    .bus_clear(u_tpb_if.bus_clear), .slow_pulse(u_tpb_if.slow_pulse));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // monitors sample at the falling edge, clear of the launching edge
  always @(negedge clk) begin
    if (u_tpb_if.command_phase_strobe === 1'b1) ca_word = u_tpb_if.exch;
    if (rx_vld === 1'b1) rx_cnt++;
    if (u_tpb_if.response_phase_strobe === 1'b1 && rc_q !== 1'b1) rc_cnt++;
    if (u_tpb_if.drive_toward_host === 1'b1 && dth_q !== 1'b1) dth_cnt++;
    if (u_tpb_if.slow_pulse[0] === 1'b1) p1_cnt++;
    if (u_tpb_if.slow_pulse[1] === 1'b1) p4_cnt++;
    if (u_tpb_if.synced_module_clock === 1'b1 && smc_q !== 1'b1) smc_cnt++;
    rc_q = u_tpb_if.response_phase_strobe;
    dth_q = u_tpb_if.drive_toward_host;
    smc_q = u_tpb_if.synced_module_clock;
  end
  task automatic print_verdict;
    $display("tests run %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] exp, input logic [31:0] got, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_count(input int exp, input int got, input string what);
    tests_run++;
    if (got != exp) begin
      failures++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  // classic single cycle; the slave sets the pace, ack or the 2000-cycle bound ends a wait
  task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= wd; sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 2000);
    rd = dat_r;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 2000) begin
      failures++;
      $display("wrong value at %0t: bus cycle never acknowledged", $time);
      print_verdict();
    end
  endtask
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0;
    dat_w = 32'h0; need_svc = 1'b0; status = 24'h0; rc_q = 1'b0; dth_q = 1'b0;
    repeat (16) @(posedge clk);
    rst_i <= 1'b0;
    wb_cycle(1'b0, ADR_STAT, 32'h0, d);
    check_word(32'h0, d, "status after reset");
    wb_cycle(1'b0, 4'h2, 32'h0, d);
    check_word(32'h0, d, "unmapped read");
    // attention follows the request level both ways
    need_svc <= 1'b1;
    repeat (4) @(posedge clk);
    wb_cycle(1'b0, ADR_STAT, 32'h0, d);
    check_word(32'h1, d & 32'h1, "attention set");
    need_svc <= 1'b0;
    repeat (4) @(posedge clk);
    wb_cycle(1'b0, ADR_STAT, 32'h0, d);
    check_word(32'h0, d & 32'h1, "attention gone");
    // back-to-back paired cycles, the middle one to an absent channel
    for (int i = 0; i < 3; i++) begin
      ch = (i == 1) ? 4'h5 : 4'h3;
      word = {TYPE_TRANSFER_OUT_PRIMARY, ch, 16'hABCD + 16'(i)};
      status <= 24'hC35A00 | 24'(i);
      n_rx = rx_cnt; n_rc = rc_cnt; n_dth = dth_cnt;
      wb_cycle(1'b1, ADR_COMMAND_ISSUE_PORT, {8'h00, word}, d);
      check_word({8'h00, word}, {8'h00, ca_word}, "command word on bus");
      repeat (3) @(posedge clk);
      check_count((ch == 4'h3) ? n_rx + 1 : n_rx, rx_cnt, "control accepts");
      if (ch == 4'h3) check_word({16'h0, word[15:0]}, {16'h0, rx_data}, "data out");
      wb_cycle(1'b0, ADR_STAT, 32'h0, d);
      check_word(32'h2, d & 32'h2, "response owed");
      wb_cycle(1'b0, ADR_DATA, 32'h0, d);
      check_count(n_rc + 1, rc_cnt, "response strobe");
      check_count((ch == 4'h3) ? n_dth + 1 : n_dth, dth_cnt, "bus turnaround");
      if (ch == 4'h3) check_word({8'h00, status}, d, "inbound word");
    end
    // a data write still strobes but is never driven outward
    n_rc = rc_cnt;
    wb_cycle(1'b1, ADR_DATA, 32'h00123456, d);
    check_count(n_rc + 1, rc_cnt, "strobe on data write");
    wb_cycle(1'b1, ADR_CTRL, 32'h1, d);
    check_word(32'h0, {16'h0, rx_data}, "control cleared");
    wb_cycle(1'b0, ADR_STAT, 32'h0, d);
    check_word(32'h0, d, "status after clear");
    // a window of whole periods holds an exact pulse count
    n1 = p1_cnt; n4 = p4_cnt;
    n_smc = smc_cnt;
    repeat (1200) @(posedge clk);
    check_count(n1 + 12, p1_cnt, "1 us pulses");
    check_count(n4 + 3, p4_cnt, "4 us pulses");
    check_count(n_smc + 1200 / STEP_CYC, smc_cnt, "module clock periods");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire

/* bench/tpb_bus_properties.sv */
/*
  tpb_bus_properties: concurrent checks on the exchange bus control levels.
  assumes one clock and a synchronous high reset; inputs are interface signals.
*/
`timescale 1ns/100ps
`default_nettype none
module tpb_bus_properties
  import tpb_pkg::*;
(
  input wire logic              clk,                   // shared clock
  input wire logic              rst_i,                 // synchronous reset, high
  input wire logic              host_exch_oe,          // processor drives exchange
  input wire logic              drive_toward_host,     // or of control send levels
  input wire logic              command_phase_strobe,  // phase a strobe
  input wire logic              response_phase_strobe, // phase b strobe
  input wire logic              bus_clear,             // clear to controls
  input wire logic [3:0]        slow_pulse             // slow timing pulses
);
  logic [CNT_W-1:0] ca_len_ff, rc_len_ff, clr_len_ff, since_ca_ff, since_rc_ff;
  logic [US_W-1:0]  p1_cnt_ff, p4_cnt_ff;
  logic             p1_seen_ff, p4_seen_ff;
  // saturating step so long levels cannot wrap back past a minimum
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction
  // length counters and gap counters; gaps start saturated so a lone strobe passes
  always_ff @(posedge clk) begin
    if (rst_i) begin
      {ca_len_ff, rc_len_ff, clr_len_ff} <= '0;
      {since_ca_ff, since_rc_ff} <= '1;
      {p1_cnt_ff, p4_cnt_ff, p1_seen_ff, p4_seen_ff} <= '0;
    end else begin
      ca_len_ff   <= command_phase_strobe ? sat_inc(ca_len_ff) : 8'h00;
      rc_len_ff   <= response_phase_strobe ? sat_inc(rc_len_ff) : 8'h00;
      clr_len_ff  <= bus_clear ? sat_inc(clr_len_ff) : 8'h00;
      since_ca_ff <= command_phase_strobe ? 8'h00 : sat_inc(since_ca_ff);
      since_rc_ff <= response_phase_strobe ? 8'h00 : sat_inc(since_rc_ff);
      p1_cnt_ff   <= slow_pulse[0] ? 10'h000 : p1_cnt_ff + 10'h001;
      p4_cnt_ff   <= slow_pulse[1] ? 10'h000 : p4_cnt_ff + 10'h001;
      p1_seen_ff  <= p1_seen_ff | slow_pulse[0];
      p4_seen_ff  <= p4_seen_ff | slow_pulse[1];
    end
  end
  default clocking dflt_cb @(posedge clk); endclocking
  default disable iff (rst_i);
  sequence ca_rise; $rose(command_phase_strobe); endsequence
  sequence rc_rise; $rose(response_phase_strobe); endsequence
  ca_width_a: assert property ($fell(command_phase_strobe) |-> ca_len_ff == STEP_CYC)
    else $error("command strobe not one bus clock long");
  rc_width_a: assert property ($fell(response_phase_strobe) |-> rc_len_ff == STEP_CYC)
    else $error("response strobe not one bus clock long");
  ca_rc_gap_a: assert property (rc_rise |-> since_ca_ff >= CA_RC_CYC - STEP_CYC)
    else $error("response strobe too soon after command strobe");
  rc_ca_gap_a: assert property (ca_rise |-> since_rc_ff >= RC_CA_CYC)
    else $error("command strobe too soon after response strobe");
  clear_len_a: assert property ($fell(bus_clear) |-> clr_len_ff >= CLR_CYC)
    else $error("bus clear shorter than three bus clocks");
  strobe_excl_a: assert property (!(command_phase_strobe && response_phase_strobe))
    else $error("both strobes high together");
  send_idle_a: assert property (command_phase_strobe |-> !drive_toward_host)
    else $error("bus turned toward processor during command phase");
  inbound_only_a: assert property (response_phase_strobe |-> !host_exch_oe)
    else $error("processor drives exchange in response phase");
  pulse_1us_a: assert property (slow_pulse[0] && p1_seen_ff |-> p1_cnt_ff == US_CYC - 1)
    else $error("1 us pulse period wrong");
  pulse_4us_a: assert property (slow_pulse[1] && p4_seen_ff |-> p4_cnt_ff == 4 * US_CYC - 1)
    else $error("4 us pulse period wrong");
endmodule // tpb_bus_properties
`default_nettype wire

/* verilog/tpb_ctrl.sv */
/*
  tpb_ctrl: one peripheral control on the exchange bus.
  assumes the processor end sequences strobes; user side is plain ports.
*/
`timescale 1ns/100ps
`default_nettype none
module tpb_ctrl
  import tpb_pkg::*;
#(
  parameter logic [CHAN_W-1:0] CHANNEL = 4'h0   // this control's channel
)(
  input  wire logic              clk_i,      // 100 MHz clock
  input  wire logic              rst_i,      // synchronous reset, high
  input  wire logic              need_svc_i, // user needs service
  input  wire logic [EXCH_W-1:0] status_i,   // word returned in phase b
  output logic [DATA_W-1:0]      rx_data_o,  // data from transfer_out_primary
  output logic                   rx_vld_o,   // one-cycle pulse on new data
  tpb_if.ctrl                    bus         // exchange bus
);
  import tpb_pkg::*;

  logic              sel_ff;       // addressed by last command
  logic              send_ff;      // drive_toward_host
  logic [DATA_W-1:0] rx_ff;
  logic              vld_ff;
  logic              attn_ff;
  logic              ca_d_ff;      // command strobe, one cycle late
  logic              rc_d_ff;      // response strobe, one cycle late

  // decode type and channel from the command word
  wire hit = bus.command_phase_strobe & (tpb_chan(bus.exch) == CHANNEL);
  wire xo  = hit & (tpb_type(bus.exch) == TYPE_TRANSFER_OUT_PRIMARY);
  wire rc_end = rc_d_ff & ~bus.response_phase_strobe;   // first cycle after response strobe

  always_ff @(posedge clk_i) begin
    if (rst_i | bus.bus_clear) begin
      sel_ff  <= 1'b0;
      send_ff <= 1'b0;
      rx_ff   <= '0;
      vld_ff  <= 1'b0;
      attn_ff <= 1'b0;
    end else begin
      if (hit) begin
        sel_ff <= 1'b1;
      end else if (rc_end) begin
        sel_ff <= 1'b0;
      end
      // send from end of command phase until response strobe ends, so the word
      // still stands at the last strobe cycle, where the host takes it
      send_ff <= sel_ff & ~bus.command_phase_strobe & ~rc_end;
      if (xo) begin
        rx_ff <= bus.exch[DATA_W-1:0];
      end
      // the word repeats through the whole strobe; report it only once
      vld_ff  <= xo & ~ca_d_ff;
      attn_ff <= need_svc_i;
    end
  end

  // remember the previous strobes to find their edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ca_d_ff <= 1'b0;
      rc_d_ff <= 1'b0;
    end else begin
      ca_d_ff <= bus.command_phase_strobe;
      rc_d_ff <= bus.response_phase_strobe;
    end
  end

  assign bus.ctrl_exch_o       = status_i;
  assign bus.ctrl_exch_oe      = send_ff;
  assign bus.drive_toward_host = send_ff;
  assign bus.attention_request = attn_ff;
  assign rx_data_o             = rx_ff;
  assign rx_vld_o              = vld_ff;
endmodule // tpb_ctrl
`default_nettype wire

/* verilog/tpb_host.sv */
/*
  tpb_host: processor end and base distribution card of the exchange bus.
  assumes a classic wishbone master on the user side and one clock.
*/
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tpb_host
  import tpb_pkg::*;
(
  input  wire logic        clk_i,    // 100 MHz clock
  input  wire logic        rst_i,    // synchronous reset, high
  input  wire logic        cyc_i,    // wishbone cycle
  input  wire logic        stb_i,    // wishbone strobe
  input  wire logic        we_i,     // wishbone write
  input  wire logic [3:0]  adr_i,    // wishbone byte address
  input  wire logic [3:0]  sel_i,    // wishbone byte selects
  input  wire logic [31:0] dat_i,    // wishbone write data
  output logic      [31:0] dat_o,    // wishbone read data
  output logic             ack_o,    // wishbone acknowledge
  tpb_if.host              bus       // exchange bus
);
  import tpb_pkg::*;

  tpb_state_t        state_ff, nxt_state;
  logic [CNT_W-1:0]  cnt_ff;                 // strobe / gap / clear length counter
  logic [CNT_W-1:0]  ca_gap_ff;              // cycles since command strobe
  logic              is_rsp_ff;              // current strobe is a response
  logic              pend_ff;                // command issued, response owed
  logic [EXCH_W-1:0] cmd_ff;                 // word driven during command
  logic              oe_ff;
  logic              ca_ff, rc_ff, clr_ff;
  logic              ctl_dirout_ff;
  logic [EXCH_W-1:0] rdata_ff;
  logic              ack_ff;
  logic [31:0]       dat_ff;
  logic              attn_s1_ff, attn_s2_ff, attn_flag_ff;
  logic              ios_s1_ff, ios_s2_ff;
  logic [4:0]        step_ff;                // bus clock phase, S1 at zero
  logic              smc_ff;
  logic [US_CNT_W-1:0] us_cnt_ff;
  logic [US_W-1:0]   us_ff;
  logic [3:0]        slow_ff;

  // request decode
  wire req      = cyc_i & stb_i & ~ack_ff;
  wire wr_command_issue_port  = req & we_i & (adr_i == ADR_COMMAND_ISSUE_PORT);
  wire acc_data = req & (adr_i == ADR_DATA);
  wire wr_ctrl  = req & we_i & (adr_i == ADR_CTRL);
  wire idle     = (state_ff == TPB_IDLE);
  wire at_s1    = (step_ff == 5'h0);
  wire bus_op   = wr_command_issue_port | acc_data | (wr_ctrl & dat_i[CT_CLR]);
  // bus operations wait for the sequencer; other accesses answer next cycle
  wire take     = req & (~bus_op | idle);
  // direction of the word about to go out, valid on the edge that takes it
  wire nxt_rsp  = (idle & take & acc_data) | (is_rsp_ff & ~(idle & take & wr_command_issue_port));
  wire us_tick  = (us_cnt_ff == US_CNT_W'(US_CYC - 1));

  // sequencer: align to step, one-bus-clock strobe, then enforce the gap
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TPB_IDLE:   if (take & bus_op) begin
                    nxt_state = (wr_ctrl) ? TPB_CLEAR : TPB_ALIGN;
                  end
      TPB_ALIGN:  if (at_s1 & (is_rsp_ff ? ca_gap_ff >= CNT_W'(CA_RC_CYC) : 1'b1)) begin
                    nxt_state = TPB_STROBE;
                  end
      TPB_STROBE: if (cnt_ff == CNT_W'(STEP_CYC - 1)) begin
                    nxt_state = TPB_GAP;
                  end
      TPB_GAP:    if (~is_rsp_ff | cnt_ff == CNT_W'(RC_CA_CYC - 1)) begin
                    nxt_state = TPB_IDLE;
                  end
      TPB_CLEAR:  if (cnt_ff == CNT_W'(CLR_CYC - 1)) begin
                    nxt_state = TPB_IDLE;
                  end
      default:    nxt_state = TPB_IDLE;
    endcase
  end

  // sequencer registers and strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= TPB_IDLE;
      cnt_ff   <= '0;
      ca_ff    <= 1'b0;
      rc_ff    <= 1'b0;
      clr_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (nxt_state != state_ff) ? '0 : cnt_ff + CNT_W'(1);
      ca_ff    <= (nxt_state == TPB_STROBE) & ~is_rsp_ff;
      rc_ff    <= (nxt_state == TPB_STROBE) & is_rsp_ff;
      clr_ff   <= (nxt_state == TPB_CLEAR);
    end
  end

  // command latch, outbound drive and pending tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      is_rsp_ff <= 1'b0;
      pend_ff   <= 1'b0;
      cmd_ff    <= '0;
      oe_ff     <= 1'b0;
      ca_gap_ff <= '0;
    end else begin
      if (idle & take & wr_command_issue_port) begin
        cmd_ff    <= dat_i[EXCH_W-1:0];
        is_rsp_ff <= 1'b0;
        pend_ff   <= 1'b1;
      end else if (idle & take & acc_data) begin
        cmd_ff    <= dat_i[EXCH_W-1:0];
        is_rsp_ff <= 1'b1;
        pend_ff   <= 1'b0;
      end
      // drive only command words: the data port is inbound only, even on a
      // write, and never drive against a sending control
      oe_ff     <= (nxt_state == TPB_ALIGN | nxt_state == TPB_STROBE)
                   & ~nxt_rsp & ~ios_s2_ff;
      ca_gap_ff <= ca_ff ? '0 : (ca_gap_ff == '1 ? ca_gap_ff : ca_gap_ff + CNT_W'(1));
    end
  end

  // inbound capture at the end of the response strobe, and bus answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff      <= '0;
      ack_ff        <= 1'b0;
      dat_ff        <= 32'h0;
      ctl_dirout_ff <= 1'b0;
    end else begin
      if (rc_ff & ~bus.host_exch_oe) begin
        rdata_ff <= bus.exch;
      end
      ack_ff <= take & ~bus_op
              | (state_ff == TPB_GAP) & (nxt_state == TPB_IDLE)
              | (state_ff == TPB_CLEAR) & (nxt_state == TPB_IDLE);
      if (take & ~we_i) begin
        case (adr_i)
          ADR_DATA: dat_ff <= {8'h0, rdata_ff};
          ADR_STAT: dat_ff <= {28'h0, clr_ff, ~idle, pend_ff, attn_flag_ff};
          ADR_CTRL: dat_ff <= {30'h0, ctl_dirout_ff, 1'b0};
          default:  dat_ff <= 32'h0;
        endcase
      end else if (state_ff == TPB_GAP & is_rsp_ff & ~we_i) begin
        dat_ff <= {8'h0, rdata_ff};
      end
      if (take & wr_ctrl & sel_i[0]) begin
        ctl_dirout_ff <= dat_i[CT_DIROUT];
      end
    end
  end

  // attention and send-direction levels cross from the control side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attn_s1_ff   <= 1'b0;
      attn_s2_ff   <= 1'b0;
      attn_flag_ff <= 1'b0;
      ios_s1_ff    <= 1'b0;
      ios_s2_ff    <= 1'b0;
    end else begin
      attn_s1_ff   <= bus.attention_request;
      attn_s2_ff   <= attn_s1_ff;
      attn_flag_ff <= attn_s2_ff;
      ios_s1_ff    <= bus.drive_toward_host;
      ios_s2_ff    <= ios_s1_ff;
    end
  end

  // step phase, module clock and slow pulses from the one clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_ff   <= '0;
      smc_ff    <= 1'b0;
      us_cnt_ff <= '0;
      us_ff     <= '0;
      slow_ff   <= '0;
    end else begin
      step_ff   <= (step_ff == 5'(STEP_CYC - 1)) ? '0 : step_ff + 5'h1;
      smc_ff    <= (step_ff < 5'(STEP_CYC / 2));
      us_cnt_ff <= us_tick ? '0 : us_cnt_ff + US_CNT_W'(1);
      if (us_tick) begin
        us_ff <= us_ff + US_W'(1);
      end
      slow_ff[0] <= us_tick & (us_ff % US_W'(SLOW_1_US) == '0);
      slow_ff[1] <= us_tick & (us_ff % US_W'(SLOW_4_US) == '0);
      slow_ff[2] <= us_tick & (us_ff % US_W'(SLOW_32_US) == '0);
      slow_ff[3] <= us_tick & (us_ff == '0);                              // 1024 us wrap
    end
  end

  // five control levels leave straight from flip-flops
  assign bus.command_phase_strobe  = ca_ff;
  assign bus.response_phase_strobe = rc_ff;
  assign bus.bus_clear             = clr_ff;
  assign bus.host_exch_o           = cmd_ff;
  assign bus.host_exch_oe          = oe_ff;
  assign bus.synced_module_clock   = smc_ff;
  assign bus.slow_pulse            = slow_ff;
  assign ack_o                     = ack_ff;
  assign dat_o                     = dat_ff;
endmodule // tpb_host
`default_nettype wire

/* verilog/tpb_if.sv */
/*
  tpb_if: the exchange bus between processor end and control end.
  assumes both ends share clk; the wire level is resolved here from enables.
*/
`timescale 1ns/100ps
`default_nettype none
interface tpb_if (input wire logic clk);
  import tpb_pkg::*;
  logic [EXCH_W-1:0] host_exch_o;      // processor drives exchange
  logic              host_exch_oe;     // processor output enable
  logic [EXCH_W-1:0] ctrl_exch_o;      // control drives exchange
  logic              ctrl_exch_oe;     // control output enable
  logic [EXCH_W-1:0] exch;             // resolved exchange level
  logic              command_phase_strobe;
  logic              response_phase_strobe;
  logic              attention_request;
  logic              bus_clear;
  logic              drive_toward_host;
  logic              synced_module_clock;
  logic [3:0]        slow_pulse;        // 1, 4, 32, 1024 us pulses
  // exchange direction follows drive_toward_host; idle bus reads zero
  assign exch = drive_toward_host ? (ctrl_exch_oe ? ctrl_exch_o : '0)
                                  : (host_exch_oe ? host_exch_o : '0);
  modport host (input exch, attention_request, drive_toward_host,
                output host_exch_o, host_exch_oe, command_phase_strobe,
                response_phase_strobe, bus_clear, synced_module_clock, slow_pulse);
  modport ctrl (input exch, command_phase_strobe, response_phase_strobe, bus_clear,
                synced_module_clock, slow_pulse,
                output ctrl_exch_o, ctrl_exch_oe, attention_request, drive_toward_host);
endinterface
`default_nettype wire

/* verilog/tpb_pkg.sv */
/*
  tpb_pkg: shared constants and types for the two-phase i/o exchange bus.
  assumes a single 100 MHz clock at both ends; no other surroundings.
*/
`default_nettype none
package tpb_pkg;
  localparam int unsigned EXCH_W        = 24;      // exchange bus width
  localparam int unsigned CHAN_W        = 4;       // channel field width
  localparam int unsigned DATA_W        = 16;      // outbound data field width
  localparam int unsigned TYPE_HI       = 23;      // cycle type field, top bit
  localparam int unsigned TYPE_LO       = 20;      // cycle type field, low bit
  localparam int unsigned CHAN_HI       = 19;      // channel field, top bit
  localparam int unsigned CHAN_LO       = 16;      // channel field, low bit
  localparam int unsigned MAX_CTRL      = 8;       // controls in the whole system
  localparam int unsigned MAX_PER_CARD  = 5;       // controls per base or extension
  localparam int unsigned NUM_CTRL_LVL  = 5;       // unidirectional control levels
  localparam logic [3:0]  TYPE_TRANSFER_OUT_PRIMARY = 4'h2;    // transfer_out_primary code
  localparam logic [3:0]  TYPE_XFROUT_B = 4'h3;    // outbound phase-b type, unused here
  // timing, in ns or bus clocks, and clock rate
  localparam int unsigned CLK_NS        = 10;      // 100 MHz clock period
  localparam int unsigned CA_RC_NS      = 500;     // least command-to-response gap
  localparam int unsigned RC_CA_PER     = 4;       // least response-to-command gap, bus clocks
  localparam int unsigned BUS_CLK_NS    = 250;     // 4 MHz system clock period
  localparam int unsigned CLR_PER       = 3;       // least bus_clear length, bus clocks
  localparam int unsigned STEP_CYC      = BUS_CLK_NS / CLK_NS;            // cycles per bus clock
  localparam int unsigned CA_RC_CYC     = (CA_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RC_CA_CYC     = RC_CA_PER * STEP_CYC;
  localparam int unsigned CLR_CYC       = CLR_PER * STEP_CYC;
  localparam int unsigned CNT_W         = 8;       // width of gap counters
  // slow timing pulse periods in us, and cycles per us
  localparam int unsigned US_CYC        = 1000 / CLK_NS;
  localparam int unsigned SLOW_1_US     = 1;
  localparam int unsigned SLOW_4_US     = 4;
  localparam int unsigned SLOW_32_US    = 32;
  localparam int unsigned SLOW_1024_US  = 1024;
  localparam int unsigned US_W          = 10;      // microsecond counter width
  localparam int unsigned US_CNT_W      = 7;       // cycle-in-microsecond counter width
  // wishbone register map (byte addresses)
  localparam logic [3:0]  ADR_DATA      = 4'h0;    // data_exchange_port, read
  localparam logic [3:0]  ADR_COMMAND_ISSUE_PORT      = 4'h4;    // command_issue_port, write
  localparam logic [3:0]  ADR_STAT      = 4'h8;    // status
  localparam logic [3:0]  ADR_CTRL      = 4'hC;    // control
  localparam int unsigned ST_ATTN       = 0;       // status: attention_flag
  localparam int unsigned ST_PEND       = 1;       // status: command awaiting response
  localparam int unsigned ST_BUSY       = 2;       // status: sequencer not idle (align, strobe, gap or clear)
  localparam int unsigned ST_CLR       = 3;        // status: bus_clear active
  localparam int unsigned CT_CLR        = 0;       // control: start bus_clear
  localparam int unsigned CT_DIROUT     = 1;       // control: outbound data write bit, stored and read back only
  typedef enum logic [2:0] {TPB_IDLE, TPB_ALIGN, TPB_STROBE, TPB_GAP, TPB_CLEAR} tpb_state_t;
  // extract the cycle type from an exchange word
  function automatic logic [3:0] tpb_type(input logic [EXCH_W-1:0] w);
    return w[TYPE_HI:TYPE_LO];
  endfunction
  // extract the channel number from an exchange word
  function automatic logic [CHAN_W-1:0] tpb_chan(input logic [EXCH_W-1:0] w);
    return w[CHAN_HI:CHAN_LO];
  endfunction
endpackage
`default_nettype wire
